// File: verilog/a5bt_pkg.sv
// Package with the register map, field layout, reset values and states of the area 5 timing block.
package a5bt_pkg;
  localparam logic [7:0] A5BT_TIMING_OFS = 8'h00;
  localparam int A5BT_WWAIT_LSB = 16;
  localparam int A5BT_SETUP_LSB = 11;
  localparam int A5BT_WR_LSB = 7;
  localparam int A5BT_MASK_BIT = 6;
  localparam int A5BT_HOLD_LSB = 0;
  localparam logic [2:0] A5BT_WWAIT_RST = 3'h0;
  localparam logic [1:0] A5BT_SETUP_RST = 2'h0;
  localparam logic [3:0] A5BT_WR_RST = 4'ha;
  localparam logic A5BT_MASK_RST = 1'b0;
  localparam logic [1:0] A5BT_HOLD_RST = 2'h0;
  localparam logic [2:0] A5BT_WWAIT_SAME = 3'h0;
  localparam logic [2:0] A5BT_WWAIT_ONE = 3'h1;
  localparam logic [4:0] A5BT_WAITS_ONE = 5'h01;
  localparam logic [4:0] A5BT_WAITS_CODE7 = 5'h08;
  localparam logic [4:0] A5BT_WAITS_CODE8 = 5'h0a;
  localparam logic [4:0] A5BT_WAITS_CODE9 = 5'h0c;
  localparam logic [4:0] A5BT_WAITS_CODEA = 5'h0e;
  localparam logic [4:0] A5BT_WAITS_CODEB = 5'h12;
  localparam logic [4:0] A5BT_WAITS_CODEC = 5'h18;
  localparam logic [7:0] A5BT_CNT_ONE = 8'h01;
  localparam logic [7:0] A5BT_CNT_ZERO = 8'h00;
  typedef enum logic [1:0] {
    A5BT_IDLE = 2'b00,
    A5BT_SETUP = 2'b01,
    A5BT_STROBE = 2'b10,
    A5BT_HOLD = 2'b11
  } a5bt_state_t;
endpackage

// File: verilog/a5bt_wait_lut.sv
// Decoder from a four-bit read wait code to a count of bus wait cycles.
`timescale 1ns/1ns
module a5bt_wait_lut
  import a5bt_pkg::*;
(
  input wire logic [3:0] i_code,
  output logic [4:0] o_waits
);
  always_comb begin
    case (i_code)
      4'h7: o_waits = A5BT_WAITS_CODE7; // see R5
      4'h8: o_waits = A5BT_WAITS_CODE8;
      4'h9: o_waits = A5BT_WAITS_CODE9;
      4'ha: o_waits = A5BT_WAITS_CODEA;
      4'hb: o_waits = A5BT_WAITS_CODEB;
      4'hc: o_waits = A5BT_WAITS_CODEC;
      4'hd, 4'he, 4'hf: o_waits = A5BT_WAITS_CODEC;
      default: o_waits = {1'b0, i_code};
    endcase
  end
endmodule

// File: verilog/a5bt_ctrl.sv
// Area 5 bus cycle timing controller with its timing register and external strobe sequencer.
// Notes on behaviour
// R1: Unused register bits read zero; software writes zero there.
// R2: Write wait code zero makes writes use the read wait count.
// R3: Nonzero write wait code inserts code minus one waits.
// R4: Setup code delays strobes after address and select by 0.5 to 3.5 cycles.
// R5: Read wait code gives 0 to 6, then 8, 10, 12, 14, 18, 24 waits.
// R6: Read wait field resets to fourteen waits; other fields reset to zero.
// R7: Software never programs the reserved read wait codes.
// R8: Mask bit clear honours external wait; set ignores it.
// R9: The wait mask applies even with zero programmed waits.
// R10: Hold code delays address and select release after strobes by 0.5 to 3.5 cycles.
// R11: Honoured external wait at the end of waits extends the strobe until released.
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ns
module a5bt_ctrl
  import a5bt_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_req,
  input wire logic i_req_write,
  input wire logic [23:0] i_req_addr,
  input wire logic [15:0] i_req_wdata,
  output logic o_busy,
  output logic o_done,
  output logic [15:0] o_resp_rdata,
  output logic [23:0] o_ext_addr,
  output logic o_chip_select_n,
  output logic o_rd_n,
  output logic o_we_n,
  output logic o_byte_lane_select_n,
  output logic [15:0] o_data_out,
  output logic o_data_oe,
  input wire logic [15:0] i_data_in,
  input wire logic i_ext_wait_n
);
  logic [2:0] write_wait_count_q;
  logic [1:0] strobe_setup_delay_q;
  logic [3:0] read_wait_code_q;
  logic external_wait_mask_q;
  logic [1:0] strobe_hold_delay_q;
  logic [31:0] rdata_q;
  a5bt_state_t state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] age_q;
  logic write_q;
  logic [23:0] addr_q;
  logic [15:0] wdata_q, resp_q;
  logic done_q;
  logic first_q;
  logic [4:0] read_waits;

  // Register decode and readback; unused bits are always zero.
  wire reg_hit = (i_addr == A5BT_TIMING_OFS);
  wire reg_wr = i_wr & reg_hit;
  wire [31:0] reg_view = {13'h0000, write_wait_count_q, 3'h0, strobe_setup_delay_q, read_wait_code_q,
                          external_wait_mask_q, 4'h0, strobe_hold_delay_q}; // see R1
  wire [31:0] rdata_d = (i_rd & reg_hit) ? reg_view : 32'h0000_0000;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      write_wait_count_q <= A5BT_WWAIT_RST; // see R6
      strobe_setup_delay_q <= A5BT_SETUP_RST;
      read_wait_code_q <= A5BT_WR_RST;
      external_wait_mask_q <= A5BT_MASK_RST;
      strobe_hold_delay_q <= A5BT_HOLD_RST;
    end else if (reg_wr) begin
      write_wait_count_q <= i_wdata[A5BT_WWAIT_LSB +: 3];
      strobe_setup_delay_q <= i_wdata[A5BT_SETUP_LSB +: 2];
      read_wait_code_q <= i_wdata[A5BT_WR_LSB +: 4];
      external_wait_mask_q <= i_wdata[A5BT_MASK_BIT];
      strobe_hold_delay_q <= i_wdata[A5BT_HOLD_LSB +: 2];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign o_rdata = rdata_q;

  a5bt_wait_lut u_wait_lut (
    .i_code(read_wait_code_q),
    .o_waits(read_waits)
  );

  // One clock is half a bus cycle, so phase lengths are counted in half cycles.
  wire [4:0] write_waits = (write_wait_count_q == A5BT_WWAIT_SAME) ? read_waits // see R2
                         : {2'b00, write_wait_count_q - A5BT_WWAIT_ONE}; // see R3
  wire [4:0] waits_sel = write_q ? write_waits : read_waits;
  wire [7:0] strobe_len = {2'b00, waits_sel + A5BT_WAITS_ONE, 1'b0};
  wire [7:0] setup_len = {5'h00, strobe_setup_delay_q, 1'b1}; // see R4
  wire [7:0] hold_len = {5'h00, strobe_hold_delay_q, 1'b1}; // see R10
  wire ext_wait = ~external_wait_mask_q & ~i_ext_wait_n; // see R8
  wire start = (state_q == A5BT_IDLE) & i_req;
  wire cnt_end = (cnt_q == A5BT_CNT_ZERO);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      A5BT_IDLE: begin
        if (i_req) begin
          state_d = A5BT_SETUP;
          cnt_d = setup_len - A5BT_CNT_ONE;
        end
      end
      A5BT_SETUP: begin
        if (cnt_end) begin
          state_d = A5BT_STROBE;
          cnt_d = strobe_len - A5BT_CNT_ONE;
        end else begin
          cnt_d = cnt_q - A5BT_CNT_ONE;
        end
      end
      A5BT_STROBE: begin
        if (cnt_end) begin
          if (!ext_wait) begin // see R9
            state_d = A5BT_HOLD;
            cnt_d = hold_len - A5BT_CNT_ONE;
          end
        end else begin
          cnt_d = cnt_q - A5BT_CNT_ONE;
        end
      end
      A5BT_HOLD: begin
        if (cnt_end) begin
          state_d = A5BT_IDLE;
        end else begin
          cnt_d = cnt_q - A5BT_CNT_ONE;
        end
      end
      default: begin
        state_d = A5BT_IDLE;
        cnt_d = A5BT_CNT_ZERO;
      end
    endcase
  end

  wire strobe_end = (state_q == A5BT_STROBE) & cnt_end & ~ext_wait; // see R11

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= A5BT_IDLE;
      cnt_q <= A5BT_CNT_ZERO;
      write_q <= 1'b0;
      addr_q <= 24'h00_0000;
      wdata_q <= 16'h0000;
      resp_q <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      done_q <= (state_q == A5BT_HOLD) & cnt_end;
      if (start) begin
        write_q <= i_req_write;
        addr_q <= i_req_addr;
        wdata_q <= i_req_wdata;
      end
      if (strobe_end & ~write_q) begin
        resp_q <= i_data_in;
      end
    end
  end

  assign o_busy = (state_q != A5BT_IDLE);
  assign o_done = done_q;
  assign o_resp_rdata = resp_q;
  assign o_ext_addr = addr_q;
  assign o_chip_select_n = (state_q == A5BT_IDLE);
  assign o_rd_n = ~((state_q == A5BT_STROBE) & ~write_q);
  assign o_we_n = ~((state_q == A5BT_STROBE) & write_q);
  assign o_byte_lane_select_n = (state_q != A5BT_STROBE);
  assign o_data_out = wdata_q;
  assign o_data_oe = write_q & o_busy;

  // Checking helpers: cycles spent in the current state and the first cycle after reset.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      age_q <= A5BT_CNT_ONE;
      first_q <= 1'b1;
    end else begin
      age_q <= (state_d != state_q) ? A5BT_CNT_ONE : age_q + A5BT_CNT_ONE;
      first_q <= 1'b0;
    end
  end

  sequence strobe_done_s;
    (state_q == A5BT_STROBE) && cnt_end && external_wait_mask_q;
  endsequence

  reserved_zero_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R1
    $past(i_rd) |-> (o_rdata[31:19] == 13'h0000) && (o_rdata[15:13] == 3'h0) && (o_rdata[5:2] == 4'h0))
    else $error("Reserved register bits read nonzero.");
  reset_value_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R6
    first_q |-> (o_rdata == 32'h0000_0000) && (read_wait_code_q == 4'ha) && (write_wait_count_q == 3'h0))
    else $error("Timing register reset value wrong.");
  setup_length_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R4
    (state_q == A5BT_SETUP) && cnt_end |-> age_q == {5'h00, strobe_setup_delay_q, 1'b1} ##1 !o_byte_lane_select_n)
    else $error("Setup delay length wrong.");
  read_length_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R5
    strobe_done_s ##0 (!write_q) |-> age_q == {2'b00, read_waits + 5'h01, 1'b0} ##1 o_rd_n)
    else $error("Read strobe length wrong.");
  write_same_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R2
    strobe_done_s ##0 (write_q && write_wait_count_q == 3'h0) |-> age_q == {2'b00, read_waits + 5'h01, 1'b0})
    else $error("Write wait does not follow read wait.");
  write_length_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R3
    strobe_done_s ##0 (write_q && write_wait_count_q != 3'h0) |-> age_q == {4'h0, write_wait_count_q, 1'b0})
    else $error("Write strobe length wrong.");
  wait_ignored_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R8
    strobe_done_s |=> o_rd_n && o_we_n)
    else $error("Masked external wait stretched the strobe.");
  wait_extend_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R11
    (state_q == A5BT_STROBE) && cnt_end && !external_wait_mask_q && !i_ext_wait_n |=> state_q == A5BT_STROBE)
    else $error("Honoured external wait did not extend the strobe.");
  hold_length_a: assert property (@(posedge i_clk) disable iff (!i_arst_n) // see R10
    (state_q == A5BT_HOLD) && cnt_end |-> age_q == {5'h00, strobe_hold_delay_q, 1'b1} ##1 o_chip_select_n)
    else $error("Hold delay length wrong.");
endmodule

// File: bench/a5bt_mem_model.sv
// Behavioural external memory that can stretch a strobe with its wait line.
`timescale 1ns/1ns
module a5bt_mem_model (
  input wire logic i_clk,
  input wire logic i_chip_select_n,
  input wire logic i_rd_n,
  input wire logic i_we_n,
  input wire logic [23:0] i_addr,
  input wire logic [15:0] i_data,
  input wire logic [3:0] i_stall,
  output logic [15:0] o_data,
  output logic o_wait_n
);
  logic [15:0] mem [16];
  logic [15:0] last_q = 16'h0;
  logic [3:0] cnt_q = 4'h0;
  wire strobe = !i_chip_select_n && !(i_rd_n && i_we_n);
  // Wait is held low for the first i_stall strobe cycles.
  assign o_wait_n = !(strobe && cnt_q < i_stall);
  // An undriven bus toggles so that stale data never passes.
  assign o_data = (strobe && !i_rd_n) ? mem[i_addr[3:0]] : ~last_q;
  always @(posedge i_clk) begin
    cnt_q <= strobe ? cnt_q + 4'h1 : 4'h0;
    if (strobe && !i_we_n) begin
      mem[i_addr[3:0]] <= i_data;
    end
    last_q <= o_data;
  end
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the area 5 bus cycle timing controller.
`timescale 1ns/1ns
module tb_top;
  import a5bt_pkg::*;
  logic i_clk = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_req = 1'b0, i_req_write = 1'b0;
  logic [7:0] i_addr = 8'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic [23:0] i_req_addr = 24'h5, o_ext_addr;
  logic [15:0] i_req_wdata = 16'h0, o_resp_rdata, o_data_out, i_data_in;
  logic [3:0] stall = 4'h0;
  logic o_busy, o_done, o_chip_select_n, o_rd_n, o_we_n, o_byte_lane_select_n, o_data_oe, i_ext_wait_n;
  int fail_count = 0, num_checks = 0;
  a5bt_ctrl dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_req(i_req), .i_req_write(i_req_write), .i_req_addr(i_req_addr),
    .i_req_wdata(i_req_wdata), .o_busy(o_busy), .o_done(o_done), .o_resp_rdata(o_resp_rdata),
    .o_ext_addr(o_ext_addr), .o_chip_select_n(o_chip_select_n), .o_rd_n(o_rd_n), .o_we_n(o_we_n),
    .o_byte_lane_select_n(o_byte_lane_select_n), .o_data_out(o_data_out), .o_data_oe(o_data_oe),
    .i_data_in(i_data_in), .i_ext_wait_n(i_ext_wait_n));
  a5bt_mem_model mem (.i_clk(i_clk), .i_chip_select_n(o_chip_select_n), .i_rd_n(o_rd_n), .i_we_n(o_we_n),
    .i_addr(o_ext_addr), .i_data(o_data_out), .i_stall(stall), .o_data(i_data_in), .o_wait_n(i_ext_wait_n));
  initial begin
    forever #25 i_clk = ~i_clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    check(o_rdata, exp);
    @(posedge i_clk);
  endtask
  // Runs one access and checks setup, strobe and hold lengths in clocks.
  task automatic acc(input logic w, input logic [15:0] d, input int s, input int t, input int h);
    int cs, ct, ch, bad;
    cs = 0;
    ct = 0;
    ch = 0;
    bad = 0;
    i_req <= 1'b1;
    i_req_write <= w;
    i_req_wdata <= d;
    @(posedge i_clk);
    i_req <= 1'b0;
    for (int n = 0; n < 200; n++) begin
      #1;
      if (o_busy !== ~o_chip_select_n || o_byte_lane_select_n !== (o_rd_n & o_we_n)) bad++;
      if (o_data_oe !== (w & ~o_chip_select_n) || (!o_chip_select_n && o_ext_addr !== 24'h5)) bad++;
      if (o_done === 1'b1) break;
      if (o_chip_select_n === 1'b0) begin
        if ((w ? o_we_n : o_rd_n) === 1'b0) ct++;
        else if (ct == 0) cs++;
        else ch++;
      end
      @(posedge i_clk);
    end
    check(cs, s);
    check(ct, t);
    check(ch, h);
    check(bad, 0);
    @(posedge i_clk);
  endtask
  function automatic int lut(input int c);
    return c < 7 ? c : c < 11 ? 2 * c - 6 : c == 11 ? 18 : 24;
  endfunction
  task automatic close_out;
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    reg_rd(8'h00, 32'h500);
    acc(1'b0, 16'h0, 1, 30, 1);
    reg_wr(8'h00, 32'h0007_1e43);
    reg_wr(8'h04, 32'h0);
    reg_rd(8'h04, 32'h0);
    reg_rd(8'h00, 32'h71e43);
    for (int c = 0; c < 13; c++) begin
      reg_wr(8'h00, 32'h40 | (c << 7) | ((c % 4) << 11) | ((c + 1) % 4));
      acc(1'b0, 16'h0, 2 * (c % 4) + 1, 2 * (lut(c) + 1), 2 * ((c + 1) % 4) + 1);
    end
    for (int c = 0; c < 8; c++) begin
      reg_wr(8'h00, 32'h40 | (c << 16) | (3 << 7));
      acc(1'b1, 16'h1234 + c, 1, 2 * ((c == 0 ? 3 : c - 1) + 1), 1);
      acc(1'b0, 16'h0, 1, 8, 1);
      check(o_resp_rdata, 16'h1234 + c);
    end
    stall <= 4'h5;
    reg_wr(8'h00, 32'h0);
    acc(1'b0, 16'h0, 1, 6, 1);
    reg_wr(8'h00, 32'h40);
    acc(1'b0, 16'h0, 1, 2, 1);
    close_out;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    close_out;
  end
endmodule
